// ==== accel_out_pair.sv ====
/*
 One 16-bit acceleration output word with block-update holding.
 Assumes byte read strobes and samples arrive on clk_sys, one per cycle.
*/
`timescale 1ns/10ps
module accel_out_pair
    import imu_regs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [15:0] sample,
    input wire logic sample_valid,
    input wire logic hold_enable,
    input wire logic rd_lsb,
    input wire logic rd_msb,
    output logic [15:0] word
);
    logic [15:0] word_ff;
    logic [15:0] pend_ff;
    logic pend_valid_ff;
    logic lsb_seen_ff;
    logic msb_seen_ff;
    logic nxt_lsb_seen;
    logic nxt_msb_seen;
    logic can_update;

    // Locked while exactly one byte of the pair has been read
    assign can_update = !hold_enable || !(lsb_seen_ff ^ msb_seen_ff);
    assign nxt_lsb_seen = lsb_seen_ff | rd_lsb;
    assign nxt_msb_seen = msb_seen_ff | rd_msb;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lsb_seen_ff <= 1'b0;
            msb_seen_ff <= 1'b0;
        end else if (nxt_lsb_seen && nxt_msb_seen) begin
            lsb_seen_ff <= 1'b0;
            msb_seen_ff <= 1'b0;
        end else begin
            lsb_seen_ff <= nxt_lsb_seen;
            msb_seen_ff <= nxt_msb_seen;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            word_ff <= ACCEL_OUT_RST;
            pend_ff <= ACCEL_OUT_RST;
            pend_valid_ff <= 1'b0;
        end else if (can_update) begin
            if (sample_valid) begin
                word_ff <= sample;
            end else if (pend_valid_ff) begin
                word_ff <= pend_ff;
            end
            pend_valid_ff <= 1'b0;
        end else if (sample_valid) begin
            pend_ff <= sample;
            pend_valid_ff <= 1'b1;
        end
    end

    assign word = word_ff;

    bdu_word_hold_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (hold_enable && (lsb_seen_ff ^ msb_seen_ff) && !rd_lsb && !rd_msb)
            |=> $stable(word_ff))
        else $error("output word changed while half read");

    cover_bdu_pending: cover property (
        @(posedge clk_sys) disable iff (!rst_n)
        pend_valid_ff && can_update);
endmodule : accel_out_pair

// ==== imu_ctrl_status_regs.sv ====
/*
 Control, self-test, event source, status and acceleration output registers
 of the combined motion sensor, reached by byte accesses from the serial
 front end. Assumes the I2C and SPI framers, the sensor core and its event
 generators all run on clk_sys and hand over one-cycle strobes.
*/
// Functional notes
// - Gyro sleep field set puts gyroscope to sleep; reset value zero.
// - Temperature-to-FIFO field set stores temperature samples in FIFO.
// - Data-available timer runs only while its enable field is one.
// - Interface field set ignores I2C accesses; SPI still answered.
// - FIFO collects data only while FIFO enable field is one.
// - Threshold-stop field set limits FIFO depth to programmed threshold.
// - Gyro self-test field enables angular-rate self-test; reset zero.
// - Accel self-test field enables acceleration self-test; reset zero.
// - Source two register: six axis flags, bit 6 any-event, bit 7 zero.
// - Source one register: same layout as source two.
// - Status bit 6 set when accelerometer interrupt events occurred.
// - Status bit 5 set when gyroscope interrupt events occurred.
// - Status bit 4 set when inactivity interrupt events occurred.
// - Status bit 3 reads one while memory boot is running.
// - Status bit 2 set when a new temperature sample exists.
// - Status bit 1 set when a new gyroscope data set exists.
// - Status bit 0 set on new accelerometer set; bit 7 zero.
// - X, Y, Z outputs are 16-bit words at 28h, 2Ah, 2Ch.
// - Block update holds a word from the cycle after its first byte is read until both are read.
// - Byte order zero puts LSB at lower address, one puts MSB.
`timescale 1ns/10ps
module imu_ctrl_status_regs
    import imu_regs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_ack,
    output ctrl_out_s ctrl,
    input wire accel_sample_s accel_sample,
    input wire logic accel_sample_valid,
    input wire logic gyro_sample_valid,
    input wire logic temp_sample_valid,
    input wire logic gyro_data_read,
    input wire logic temp_data_read,
    input wire logic [5:0] accel_evt_one,
    input wire logic [5:0] accel_evt_two,
    input wire logic gyro_irq_level,
    input wire logic inactivity_level,
    input wire logic boot_running,
    input wire logic block_update_hold,
    input wire logic byte_order_select
);
    logic rst_n;
    logic [7:0] fifo_iface_ff;
    logic [7:0] selftest_ff;
    logic [5:0] src_one_ff;
    logic [5:0] src_two_ff;
    logic gyro_irq_ff;
    logic inactivity_ff;
    logic boot_ff;
    logic temp_new_ff;
    logic gyro_new_ff;
    logic accel_new_ff;
    logic [7:0] reg_rdata_ff;
    logic reg_ack_ff;
    logic access_ok;
    logic wr_ok;
    logic rd_ok;
    logic accel_irq_flag;
    logic accel_out_read;
    logic [7:0] status_byte;
    logic [7:0] nxt_rdata;
    logic [15:0] axis_word [AXES];
    logic [15:0] axis_sample [AXES];
    logic [AXES-1:0] rd_lsb;
    logic [AXES-1:0] rd_msb;

    // Two-byte output window for one axis
    function automatic logic in_pair(input logic [7:0] addr,
                                     input logic [7:0] base);
        in_pair = (addr[7:1] == base[7:1]);
    endfunction : in_pair

    // Byte of a word that sits at the given address, honouring byte order
    function automatic logic [7:0] pair_byte(input logic [15:0] word,
                                             input logic upper_addr,
                                             input logic msb_first);
        pair_byte = (upper_addr ^ msb_first) ? word[15:8] : word[7:0];
    endfunction : pair_byte

    reset_release u_reset_release (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .rst_n(rst_n)
    );

    // Access gating by interface source
    assign access_ok = !(reg_req.from_i2c &&
                         fifo_iface_ff[BIT_SPI_ONLY]);
    assign wr_ok = reg_req.wr && access_ok;
    assign rd_ok = reg_req.rd && access_ok;
    assign accel_out_read = rd_ok && (in_pair(reg_req.addr, OFS_ACCEL_X) ||
                                      in_pair(reg_req.addr, OFS_ACCEL_Y) ||
                                      in_pair(reg_req.addr, OFS_ACCEL_Z));

    // Control registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fifo_iface_ff <= FIFO_IFACE_RST;
        end else if (wr_ok && reg_req.addr == OFS_FIFO_IFACE_CTRL) begin
            fifo_iface_ff <= reg_req.wdata & FIFO_IFACE_MASK;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            selftest_ff <= SELFTEST_RST;
        end else if (wr_ok && reg_req.addr == OFS_SELFTEST_CTRL) begin
            selftest_ff <= reg_req.wdata & SELFTEST_MASK;
        end
    end

    assign ctrl.gyro_sleep = fifo_iface_ff[BIT_GYRO_SLEEP];
    assign ctrl.temp_to_fifo = fifo_iface_ff[BIT_TEMP_TO_FIFO];
    assign ctrl.data_avail_timer_enable = fifo_iface_ff[BIT_DA_TIMER];
    assign ctrl.spi_only = fifo_iface_ff[BIT_SPI_ONLY];
    assign ctrl.fifo_enable = fifo_iface_ff[BIT_FIFO_ENABLE];
    assign ctrl.threshold_stop = fifo_iface_ff[BIT_THRESHOLD_STOP];
    assign ctrl.gyro_selftest_enable = selftest_ff[BIT_GYRO_SELFTEST];
    assign ctrl.accel_selftest_enable = selftest_ff[BIT_ACCEL_SELFTEST];

    // Sticky event sources, cleared by reading; a new event wins the clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            src_two_ff <= EVT_SRC_RST;
        end else if (rd_ok && reg_req.addr == OFS_EVT_SRC_TWO) begin
            src_two_ff <= accel_evt_two;
        end else begin
            src_two_ff <= src_two_ff | accel_evt_two;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            src_one_ff <= EVT_SRC_RST;
        end else if (rd_ok && reg_req.addr == OFS_EVT_SRC_ONE) begin
            src_one_ff <= accel_evt_one;
        end else begin
            src_one_ff <= src_one_ff | accel_evt_one;
        end
    end

    assign accel_irq_flag = (|src_one_ff) || (|src_two_ff);

    // Interrupt and boot levels from the core
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gyro_irq_ff <= 1'b0;
            inactivity_ff <= 1'b0;
            boot_ff <= 1'b0;
        end else begin
            gyro_irq_ff <= gyro_irq_level;
            inactivity_ff <= inactivity_level;
            boot_ff <= boot_running;
        end
    end

    // Data-available flags; a new sample wins over the read that clears
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            temp_new_ff <= 1'b0;
            gyro_new_ff <= 1'b0;
            accel_new_ff <= 1'b0;
        end else begin
            temp_new_ff <= temp_sample_valid ||
                           (temp_new_ff && !temp_data_read);
            gyro_new_ff <= gyro_sample_valid ||
                           (gyro_new_ff && !gyro_data_read);
            accel_new_ff <= accel_sample_valid ||
                            (accel_new_ff && !accel_out_read);
        end
    end

    assign status_byte = {1'b0, accel_irq_flag, gyro_irq_ff, inactivity_ff,
                          boot_ff, temp_new_ff, gyro_new_ff,
                          accel_new_ff};

    // Output words, one per axis
    assign axis_sample[0] = accel_sample.x;
    assign axis_sample[1] = accel_sample.y;
    assign axis_sample[2] = accel_sample.z;

    genvar g;
    generate
        for (g = 0; g < AXES; g++) begin : g_axis
            localparam logic [7:0] BASE = OFS_ACCEL_X + 8'(2 * g);
            logic hit;
            assign hit = rd_ok && in_pair(reg_req.addr, BASE);
            assign rd_lsb[g] = hit &&
                               (reg_req.addr[0] == byte_order_select);
            assign rd_msb[g] = hit &&
                               (reg_req.addr[0] != byte_order_select);
            accel_out_pair u_pair (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .sample(axis_sample[g]),
                .sample_valid(accel_sample_valid),
                .hold_enable(block_update_hold),
                .rd_lsb(rd_lsb[g]),
                .rd_msb(rd_msb[g]),
                .word(axis_word[g])
            );
        end
    endgenerate

    // Read data selection
    always_comb begin
        nxt_rdata = RDATA_RST;
        if (in_pair(reg_req.addr, OFS_ACCEL_X)) begin
            nxt_rdata = pair_byte(axis_word[0], reg_req.addr[0],
                                  byte_order_select);
        end else if (in_pair(reg_req.addr, OFS_ACCEL_Y)) begin
            nxt_rdata = pair_byte(axis_word[1], reg_req.addr[0],
                                  byte_order_select);
        end else if (in_pair(reg_req.addr, OFS_ACCEL_Z)) begin
            nxt_rdata = pair_byte(axis_word[2], reg_req.addr[0],
                                  byte_order_select);
        end else begin
            case (reg_req.addr)
                OFS_FIFO_IFACE_CTRL: nxt_rdata = fifo_iface_ff;
                OFS_SELFTEST_CTRL: nxt_rdata = selftest_ff;
                OFS_EVT_SRC_TWO: begin
                    nxt_rdata = {1'b0, |src_two_ff, src_two_ff};
                end
                OFS_EVT_SRC_ONE: begin
                    nxt_rdata = {1'b0, |src_one_ff, src_one_ff};
                end
                OFS_STATUS: nxt_rdata = status_byte;
                default: nxt_rdata = RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_ff <= RDATA_RST;
        end else if (rd_ok) begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_ack_ff <= 1'b0;
        end else begin
            reg_ack_ff <= wr_ok || rd_ok;
        end
    end

    assign reg_rdata = reg_rdata_ff;
    assign reg_ack = reg_ack_ff;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    fifo_ctrl_write_a: assert property (
        (wr_ok && reg_req.addr == OFS_FIFO_IFACE_CTRL) |=>
            ({ctrl.gyro_sleep, 1'b0, ctrl.temp_to_fifo,
              ctrl.data_avail_timer_enable, ctrl.spi_only, ctrl.fifo_enable,
              ctrl.threshold_stop} == ($past(reg_req.wdata[6:0]) &
              FIFO_IFACE_MASK[6:0])))
        else $error("fifo control fields do not follow the write");

    selftest_write_a: assert property (
        (wr_ok && reg_req.addr == OFS_SELFTEST_CTRL) |=>
            (ctrl.gyro_selftest_enable == $past(reg_req.wdata[2]) &&
             ctrl.accel_selftest_enable == $past(reg_req.wdata[0])))
        else $error("self-test fields do not follow the write");

    reserved_zero_a: assert property (
        (rd_ok && (reg_req.addr == OFS_FIFO_IFACE_CTRL ||
                   reg_req.addr == OFS_SELFTEST_CTRL)) |=>
            ((reg_rdata & ~FIFO_IFACE_MASK) == 8'h00))
        else $error("reserved control bit reads one");

    i2c_refused_a: assert property (
        (reg_req.from_i2c && ctrl.spi_only && (reg_req.wr || reg_req.rd) &&
         !(reg_req.wr && reg_req.addr == OFS_FIFO_IFACE_CTRL))
            |=> (!reg_ack && $stable(reg_rdata) && $stable(fifo_iface_ff)))
        else $error("i2c access answered while disabled");

    src_layout_a: assert property (
        (rd_ok && (reg_req.addr == OFS_EVT_SRC_TWO ||
                   reg_req.addr == OFS_EVT_SRC_ONE)) |=>
            (!reg_rdata[7] && reg_rdata[6] == (|reg_rdata[5:0])))
        else $error("event source layout wrong");

    evt_set_wins_a: assert property (
        (accel_evt_one != 6'h00) |=>
            ((src_one_ff & $past(accel_evt_one)) == $past(accel_evt_one)))
        else $error("accel event lost");

    evt_two_wins_a: assert property (
        (accel_evt_two != 6'h00) |=>
            ((src_two_ff & $past(accel_evt_two)) == $past(accel_evt_two)))
        else $error("accel event two lost");

    status_read_a: assert property (
        (rd_ok && reg_req.addr == OFS_STATUS) |=>
            (reg_rdata[7:3] == {1'b0, $past(accel_irq_flag),
                                $past(gyro_irq_level, 2),
                                $past(inactivity_level, 2),
                                $past(boot_running, 2)}))
        else $error("status read disagrees with flags");

    accel_new_a: assert property (
        (accel_out_read && !accel_sample_valid) |=> !accel_new_ff ##1
            (accel_new_ff == $past(accel_sample_valid)))
        else $error("accel data flag not cleared by read");

    gyro_new_clear_a: assert property (
        (gyro_data_read && !gyro_sample_valid) |=> !gyro_new_ff)
        else $error("gyro data flag not cleared by read");

    temp_new_clear_a: assert property (
        (temp_data_read && !temp_sample_valid) |=> !temp_new_ff)
        else $error("temp data flag not cleared by read");

    sample_sets_flag_a: assert property (
        (temp_sample_valid || gyro_sample_valid || accel_sample_valid) |=>
            ((status_byte[2:0] & $past({temp_sample_valid,
              gyro_sample_valid, accel_sample_valid})) ==
             $past({temp_sample_valid, gyro_sample_valid,
                    accel_sample_valid})))
        else $error("new data flags not set");

    byte_order_a: assert property (
        (rd_ok && reg_req.addr == OFS_ACCEL_X && !byte_order_select &&
         !accel_sample_valid) |=> (reg_rdata == $past(axis_word[0][7:0])))
        else $error("lower address byte order wrong");

    cover_i2c_refused: cover property (
        reg_req.from_i2c && ctrl.spi_only && reg_req.rd);
    cover_event_read: cover property (
        (rd_ok && reg_req.addr == OFS_EVT_SRC_ONE) ##1 reg_rdata[6]);
    cover_msb_first: cover property (
        rd_ok && reg_req.addr == OFS_ACCEL_Z && byte_order_select);
endmodule : imu_ctrl_status_regs

// ==== imu_ctrl_status_regs_tb.sv ====
/*
 Self-checking testbench of the control and status register slice.
 Assumes the host model drives the register port; core inputs come from here.
*/
`timescale 1ns/10ps
module imu_ctrl_status_regs_tb;
    import imu_regs_pkg::*;
    logic clk_sys;
    logic resetn;
    reg_req_s reg_req;
    logic [7:0] reg_rdata;
    logic reg_ack;
    ctrl_out_s ctrl;
    accel_sample_s accel_sample;
    logic accel_sample_valid;
    logic gyro_sample_valid;
    logic temp_sample_valid;
    logic gyro_data_read;
    logic temp_data_read;
    logic [5:0] accel_evt_one;
    logic [5:0] accel_evt_two;
    logic gyro_irq_level;
    logic inactivity_level;
    logic boot_running;
    logic block_update_hold;
    logic byte_order_select;
    int n_fail;
    int samples_checked;

    imu_ctrl_status_regs dut (.clk_sys(clk_sys), .resetn(resetn),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .ctrl(ctrl), .accel_sample(accel_sample),
        .accel_sample_valid(accel_sample_valid),
        .gyro_sample_valid(gyro_sample_valid),
        .temp_sample_valid(temp_sample_valid),
        .gyro_data_read(gyro_data_read), .temp_data_read(temp_data_read),
        .accel_evt_one(accel_evt_one), .accel_evt_two(accel_evt_two),
        .gyro_irq_level(gyro_irq_level), .inactivity_level(inactivity_level),
        .boot_running(boot_running), .block_update_hold(block_update_hold),
        .byte_order_select(byte_order_select));

    imu_host_model host (.clk_sys(clk_sys), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] addr, input logic i2c,
        input logic [7:0] exp, input logic exp_ack);
        logic [7:0] d;
        logic a;
        host.access(1'b0, addr, 8'h00, i2c, d, a);
        chk($sformatf("ack of read %h", addr), {7'h00, exp_ack}, {7'h00, a});
        if (exp_ack) begin
            chk($sformatf("read %h", addr), exp, d);
        end
    endtask : rd_chk

    task automatic wr(input logic [7:0] addr, input logic [7:0] data,
        input logic i2c, input logic exp_ack);
        logic [7:0] d;
        logic a;
        host.access(1'b1, addr, data, i2c, d, a);
        chk($sformatf("ack of write %h", addr), {7'h00, exp_ack}, {7'h00, a});
    endtask : wr

    // Order: evt_two, evt_one, accel/gyro/temp valid, gyro/temp read
    task automatic pulse(input logic [16:0] v);
        @(posedge clk_sys);
        {accel_evt_two, accel_evt_one, accel_sample_valid, gyro_sample_valid,
            temp_sample_valid, gyro_data_read, temp_data_read} <= v;
        @(posedge clk_sys);
        {accel_evt_two, accel_evt_one, accel_sample_valid, gyro_sample_valid,
            temp_sample_valid, gyro_data_read, temp_data_read} <= 17'h00000;
    endtask : pulse

    task automatic levels(input logic [2:0] v);
        @(posedge clk_sys);
        {gyro_irq_level, inactivity_level, boot_running} <= v;
    endtask : levels

    task automatic sample(input logic [47:0] v);
        @(posedge clk_sys);
        accel_sample <= v;
        pulse(17'h00010);
    endtask : sample

    task automatic t_reset;
        chk("ctrl after reset", 8'h00, ctrl);
        for (int a = 8'h23; a <= 8'h2d; a++) begin
            rd_chk(a[7:0], 1'b0, 8'h00, 1'b1);
        end
    endtask : t_reset

    task automatic t_ctrl;
        logic [7:0] pos [6] = '{8'h40, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
        for (int i = 0; i < 6; i++) begin
            wr(OFS_FIFO_IFACE_CTRL, pos[i], 1'b0, 1'b1);
            chk("ctrl field", 8'h80 >> i, ctrl);
        end
        wr(OFS_SELFTEST_CTRL, 8'h04, 1'b0, 1'b1);
        chk("gyro self-test", 8'h06, ctrl);
        wr(OFS_SELFTEST_CTRL, 8'h01, 1'b0, 1'b1);
        chk("accel self-test", 8'h05, ctrl);
        wr(OFS_FIFO_IFACE_CTRL, 8'h5f, 1'b0, 1'b1);
        rd_chk(OFS_FIFO_IFACE_CTRL, 1'b0, 8'h5f, 1'b1);
        wr(OFS_SELFTEST_CTRL, 8'h05, 1'b0, 1'b1);
        rd_chk(OFS_SELFTEST_CTRL, 1'b0, 8'h05, 1'b1);
        chk("all fields", 8'hff, ctrl);
        rd_chk(OFS_FIFO_IFACE_CTRL, 1'b1, 8'h00, 1'b0);
        wr(OFS_FIFO_IFACE_CTRL, 8'h00, 1'b1, 1'b0);
        rd_chk(OFS_FIFO_IFACE_CTRL, 1'b0, 8'h5f, 1'b1);
        wr(OFS_FIFO_IFACE_CTRL, 8'h00, 1'b0, 1'b1);
        wr(OFS_SELFTEST_CTRL, 8'h00, 1'b1, 1'b1);
        rd_chk(OFS_FIFO_IFACE_CTRL, 1'b1, 8'h00, 1'b1);
        chk("ctrl cleared", 8'h00, ctrl);
    endtask : t_ctrl

    task automatic t_events;
        logic [7:0] src;
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 6; k++) begin
                src = s ? OFS_EVT_SRC_TWO : OFS_EVT_SRC_ONE;
                pulse((17'h00001 << (5 + k)) << (6 * s));
                rd_chk(OFS_STATUS, 1'b0, 8'h40, 1'b1);
                rd_chk(src, 1'b0, 8'h40 | (8'h01 << k), 1'b1);
                rd_chk(src, 1'b0, 8'h00, 1'b1);
                rd_chk(OFS_STATUS, 1'b0, 8'h00, 1'b1);
            end
        end
    endtask : t_events

    task automatic t_status;
        levels(3'b100);
        rd_chk(OFS_STATUS, 1'b0, 8'h20, 1'b1);
        levels(3'b110);
        rd_chk(OFS_STATUS, 1'b0, 8'h30, 1'b1);
        levels(3'b111);
        rd_chk(OFS_STATUS, 1'b0, 8'h38, 1'b1);
        levels(3'b000);
        rd_chk(OFS_STATUS, 1'b0, 8'h00, 1'b1);
        pulse(17'h00008);
        rd_chk(OFS_STATUS, 1'b0, 8'h02, 1'b1);
        pulse(17'h00004);
        rd_chk(OFS_STATUS, 1'b0, 8'h06, 1'b1);
        pulse(17'h00010);
        rd_chk(OFS_STATUS, 1'b0, 8'h07, 1'b1);
        pulse(17'h00002);
        rd_chk(OFS_STATUS, 1'b0, 8'h05, 1'b1);
        pulse(17'h00001);
        rd_chk(OFS_STATUS, 1'b0, 8'h01, 1'b1);
        rd_chk(OFS_ACCEL_Z, 1'b0, 8'h00, 1'b1);
        rd_chk(OFS_STATUS, 1'b0, 8'h00, 1'b1);
    endtask : t_status

    task automatic t_out;
        logic [47:0] v;
        logic [15:0] w;
        v = 48'h8123_7f45_fe67;
        sample(v);
        for (int o = 0; o < 2; o++) begin
            @(posedge clk_sys);
            byte_order_select <= o[0];
            for (int i = 0; i < 6; i++) begin
                w = v[47 - 16 * (i / 2) -: 16];
                rd_chk(OFS_ACCEL_X + i[7:0], 1'b0,
                    (i[0] ^ o[0]) ? w[15:8] : w[7:0], 1'b1);
            end
        end
        @(posedge clk_sys);
        byte_order_select <= 1'b0;
    endtask : t_out

    task automatic t_hold;
        @(posedge clk_sys);
        block_update_hold <= 1'b1;
        sample(48'ha1b2_0000_0000);
        rd_chk(OFS_ACCEL_X, 1'b0, 8'hb2, 1'b1);
        sample(48'hc3d4_0000_0000);
        rd_chk(OFS_ACCEL_X, 1'b0, 8'hb2, 1'b1);
        rd_chk(OFS_ACCEL_X + 8'h01, 1'b0, 8'ha1, 1'b1);
        repeat (3) @(posedge clk_sys);
        rd_chk(OFS_ACCEL_X, 1'b0, 8'hd4, 1'b1);
        rd_chk(OFS_ACCEL_X + 8'h01, 1'b0, 8'hc3, 1'b1);
        @(posedge clk_sys);
        block_update_hold <= 1'b0;
        sample(48'h0e0f_0000_0000);
        rd_chk(OFS_ACCEL_X, 1'b0, 8'h0f, 1'b1);
        sample(48'h1a2b_0000_0000);
        rd_chk(OFS_ACCEL_X + 8'h01, 1'b0, 8'h1a, 1'b1);
    endtask : t_hold

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #200000;
        n_fail++;
        report_and_stop();
    end

    initial begin
        n_fail = 0;
        samples_checked = 0;
        resetn = 1'b0;
        accel_sample = '0;
        {accel_evt_two, accel_evt_one, accel_sample_valid, gyro_sample_valid,
            temp_sample_valid, gyro_data_read, temp_data_read} = 17'h00000;
        {gyro_irq_level, inactivity_level, boot_running} = 3'b000;
        block_update_hold = 1'b0;
        byte_order_select = 1'b0;
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_reset();
        t_ctrl();
        t_events();
        t_status();
        t_out();
        t_hold();
        report_and_stop();
    end
endmodule : imu_ctrl_status_regs_tb

// ==== imu_host_model.sv ====
/*
 Host side of the register port: one byte access per call.
 Assumes the register slice answers with reg_ack one cycle after taking.
*/
`timescale 1ns/10ps
module imu_host_model
    import imu_regs_pkg::*;
(
    input wire logic clk_sys,
    output reg_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_ack
);
    initial begin
        reg_req = '0;
    end

    // Strobe for one taking edge, then released lines show inverted values
    task automatic access(input logic wr, input logic [7:0] addr,
        input logic [7:0] wdata, input logic i2c,
        output logic [7:0] rdata, output logic ack);
        @(posedge clk_sys);
        reg_req <= '{addr, wdata, wr, !wr, i2c};
        @(posedge clk_sys);
        reg_req <= '{~addr, ~wdata, 1'b0, 1'b0, !i2c};
        @(posedge clk_sys);
        rdata = reg_rdata;
        ack = reg_ack;
    endtask : access
endmodule : imu_host_model

// ==== imu_regs_pkg.sv ====
/*
 Constants, field positions, reset values and carrier types shared by the
 control and status register slice and its helper modules.
 Assumes byte-wide register accesses that arrive on the sensor core clock.
*/
package imu_regs_pkg;

    // Register offsets
    localparam logic [7:0] OFS_FIFO_IFACE_CTRL = 8'h23;
    localparam logic [7:0] OFS_SELFTEST_CTRL = 8'h24;
    localparam logic [7:0] OFS_EVT_SRC_TWO = 8'h25;
    localparam logic [7:0] OFS_EVT_SRC_ONE = 8'h26;
    localparam logic [7:0] OFS_STATUS = 8'h27;
    localparam logic [7:0] OFS_ACCEL_X = 8'h28;
    localparam logic [7:0] OFS_ACCEL_Y = 8'h2a;
    localparam logic [7:0] OFS_ACCEL_Z = 8'h2c;

    // Field positions of the FIFO and interface control register
    localparam int BIT_GYRO_SLEEP = 6;
    localparam int BIT_TEMP_TO_FIFO = 4;
    localparam int BIT_DA_TIMER = 3;
    localparam int BIT_SPI_ONLY = 2;
    localparam int BIT_FIFO_ENABLE = 1;
    localparam int BIT_THRESHOLD_STOP = 0;

    // Field positions of the self-test control register
    localparam int BIT_GYRO_SELFTEST = 2;
    localparam int BIT_ACCEL_SELFTEST = 0;

    // Writable bits; every other position is reserved and reads zero
    localparam logic [7:0] FIFO_IFACE_MASK = 8'h5f;
    localparam logic [7:0] SELFTEST_MASK = 8'h05;

    // Reset values
    localparam logic [7:0] FIFO_IFACE_RST = 8'h00;
    localparam logic [7:0] SELFTEST_RST = 8'h00;
    localparam logic [5:0] EVT_SRC_RST = 6'h00;
    localparam logic [15:0] ACCEL_OUT_RST = 16'h0000;
    localparam logic [7:0] RDATA_RST = 8'h00;

    localparam int AXES = 3;

    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } accel_sample_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic from_i2c;
    } reg_req_s;

    typedef struct packed {
        logic gyro_sleep;
        logic temp_to_fifo;
        logic data_avail_timer_enable;
        logic spi_only;
        logic fifo_enable;
        logic threshold_stop;
        logic gyro_selftest_enable;
        logic accel_selftest_enable;
    } ctrl_out_s;

endpackage : imu_regs_pkg

// ==== reset_release.sv ====
/*
 Two-stage release of the active-low asynchronous reset.
 Assumes resetn may drop at any time and is released without regard to clk.
*/
`timescale 1ns/10ps
module reset_release (
    input wire logic clk_sys,
    input wire logic resetn,
    output logic rst_n
);
    logic stage_ff;
    logic hold_ff;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stage_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else begin
            stage_ff <= 1'b1;
            hold_ff <= stage_ff;
        end
    end

    assign rst_n = hold_ff;
endmodule : reset_release
